// >>> rtl/mfc_map.vh
/*
 Constants for the multifunction counter control block: strobe indices,
 mode codes, range codes, divider counts and strobe timing.
 Assumes a single 250 MHz clock and plain Verilog-2005 includers.
*/
`ifndef MFC_MAP_VH
`define MFC_MAP_VH
`define MFC_MODE_FREQ 3'h0
`define MFC_MODE_PERIOD 3'h1
`define MFC_MODE_RATIO 3'h2
`define MFC_MODE_INTERVAL 3'h3
`define MFC_MODE_UNIT 3'h4
`define MFC_MODE_SELFTEST 3'h5
`define MFC_STB_FIRST 3'h0
`define MFC_STB_SECOND 3'h1
`define MFC_STB_THIRD 3'h2
`define MFC_STB_FOURTH 3'h3
`define MFC_STB_FIFTH 3'h4
`define MFC_STB_EIGHTH 3'h7
`define MFC_CLK_MHZ 250
`define MFC_STROBE_US 250
`define MFC_STROBE_CYC (`MFC_STROBE_US * `MFC_CLK_MHZ)
`define MFC_SAMPLE_CYC (`MFC_STROBE_CYC - 1)
`define MFC_DIV_10M 17'd99999
`define MFC_DIV_1M 17'd9999
`define MFC_DEC_MAX 4'h9
`define MFC_RANGE_RST 2'h0
`define MFC_MODE_RST 3'h0
`endif

// >>> rtl/mfc_latch.v
/*
 Display latch: holds the eight decade digits shown on the display.
 Assumes its load strobe comes from the control block on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mfc_latch (
   input wire i_clk,          // system clock
   input wire i_reset_n,      // async reset, active low
   input wire i_load,         // load pulse
   input wire [31:0] i_data,  // bcd digits to store
   output reg [31:0] o_data   // registered display value
);
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= 32'h0;
      end else if (i_load) begin
         o_data <= i_data;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/mfc_ctrl.v
/*
 Multifunction counter control: strobe scan, selection decode, routing of
 inputs A, B and the timebase to the main and reference counters, windows,
 abort, hold and display latching.
 Assumes the timebase arrives as a pin level; all pins are synchronised
 here, so timebase and inputs must be well below a quarter of the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"
module mfc_ctrl #(
   parameter STROBE_CYC = `MFC_STROBE_CYC   // cycles per digit strobe
) (
   input wire i_clk,              // 250 MHz clock
   input wire i_reset_n,          // async reset, active low
   input wire i_in_a,             // measurement input A
   input wire i_in_b,             // measurement input B
   input wire i_osc,              // on-board timebase level
   input wire i_ext_osc,          // external timebase level
   input wire i_hold,             // hold, active high
   input wire i_function_n,       // function selection line, active low
   input wire i_range_n,          // range selection line, active low
   input wire i_control_n,        // control selection line, active low
   input wire i_ext_point_select_line_n, // external point line, active low
   output reg [7:0] o_digit_strobe,  // one-hot digit scan
   output reg [2:0] o_mode,       // decoded operating mode
   output reg [1:0] o_range,      // decoded range 0..3
   output reg o_display_off,      // display off selected
   output reg o_display_test,     // display test selected
   output reg o_sel_1mhz,         // 1MHz timebase selected
   output reg o_sel_ext_osc,      // external timebase selected
   output reg [7:0] o_point,      // decimal point per digit
   output reg o_meas_busy,        // measurement in progress
   output reg o_overflow,         // main counter overflowed
   output wire [31:0] o_display   // latched bcd count
);
   localparam [31:0] LAST_CYC = STROBE_CYC - 1;
   reg [2:0] a_s_r, b_s_r, o_s_r, e_s_r;
   reg [1:0] h_s_r, f_s_r, r_s_r, c_s_r, p_s_r;
   reg [17:0] scan_cnt_r;
   reg [2:0] scan_idx_r;
   reg [7:0] ctl_acc_r;
   reg [7:0] pt_acc_r;
   reg [2:0] mode_pend_r;
   reg [1:0] range_pend_r;
   reg fsel_seen_r, rsel_seen_r;
   reg [7:0] ext_pt_r;
   reg ext_pt_en_r;
   reg [16:0] div_r;
   reg [31:0] main_r;
   reg [15:0] ref_r;
   reg gate_r, armed_r, load_r;
   reg [2:0] mode_prev_r;
   reg [1:0] range_prev_r;
   reg hold_prev_r;
   reg [31:0] main_nxt;
   reg [15:0] ref_nxt;
   wire a_fall, b_fall, tb_fall, tick, sample, abort, main_ev, ref_ev, ref_end;
   wire [31:0] ref_inc_w;
   wire [31:0] main_inc;
   wire [15:0] ref_inc;

   // one bcd increment of a packed decade string
   function [31:0] bcd_inc;
      input [31:0] v;
      input [3:0] n;
      integer k;
      reg c;
      begin
         bcd_inc = v;
         c = 1'b1;
         for (k = 0; k < 8; k = k + 1) begin
            if (k < n && c) begin
               if (v[k*4 +: 4] == `MFC_DEC_MAX) begin
                  bcd_inc[k*4 +: 4] = 4'h0;
               end else begin
                  bcd_inc[k*4 +: 4] = v[k*4 +: 4] + 4'h1;
                  c = 1'b0;
               end
            end
         end
      end
   endfunction

   // falling edge from the two synchronised stages
   function fall;
      input [2:0] s;
      begin
         fall = s[2] & ~s[1];
      end
   endfunction

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         a_s_r <= 3'h0;
         b_s_r <= 3'h0;
         o_s_r <= 3'h0;
         e_s_r <= 3'h0;
         h_s_r <= 2'h0;
         f_s_r <= 2'h3;
         r_s_r <= 2'h3;
         c_s_r <= 2'h3;
         p_s_r <= 2'h3;
      end else begin
         a_s_r <= {a_s_r[1:0], i_in_a};
         b_s_r <= {b_s_r[1:0], i_in_b};
         o_s_r <= {o_s_r[1:0], i_osc};
         e_s_r <= {e_s_r[1:0], i_ext_osc};
         h_s_r <= {h_s_r[0], i_hold};
         f_s_r <= {f_s_r[0], i_function_n};
         r_s_r <= {r_s_r[0], i_range_n};
         c_s_r <= {c_s_r[0], i_control_n};
         p_s_r <= {p_s_r[0], i_ext_point_select_line_n};
      end
   end

   // edges taken from stages two and three only
   assign a_fall = fall(a_s_r);
   assign b_fall = fall(b_s_r);
   assign tb_fall = o_sel_ext_osc ? fall(e_s_r) : fall(o_s_r);
   assign sample = ({14'h0, scan_cnt_r} == LAST_CYC);
   // sample at the strobe's last cycle, inside the settled half

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scan_cnt_r <= 18'h0;
         scan_idx_r <= 3'h0;
         o_digit_strobe <= 8'h01;
      end else if (sample) begin
         scan_cnt_r <= 18'h0;
         scan_idx_r <= scan_idx_r + 3'h1;
         o_digit_strobe <= {o_digit_strobe[6:0], o_digit_strobe[7]};
      end else begin
         scan_cnt_r <= scan_cnt_r + 18'h1;
      end
   end

   // selection decode: a low line while a strobe is up selects it
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_acc_r <= 8'h0;
         pt_acc_r <= 8'h0;
         mode_pend_r <= `MFC_MODE_RST;
         range_pend_r <= `MFC_RANGE_RST;
         fsel_seen_r <= 1'b0;
         rsel_seen_r <= 1'b0;
         o_mode <= `MFC_MODE_RST;
         o_range <= `MFC_RANGE_RST;
         o_display_off <= 1'b0;
         o_display_test <= 1'b0;
         o_sel_1mhz <= 1'b0;
         o_sel_ext_osc <= 1'b0;
         ext_pt_r <= 8'h0;
         ext_pt_en_r <= 1'b0;
      end else if (sample && !(o_display_off && h_s_r[1])) begin
         if (!f_s_r[1]) begin
            fsel_seen_r <= 1'b1;
            case (scan_idx_r)
               `MFC_STB_FIRST: mode_pend_r <= `MFC_MODE_FREQ;
               `MFC_STB_EIGHTH: mode_pend_r <= `MFC_MODE_PERIOD;
               `MFC_STB_SECOND: mode_pend_r <= `MFC_MODE_RATIO;
               `MFC_STB_FIFTH: mode_pend_r <= `MFC_MODE_INTERVAL;
               `MFC_STB_FOURTH: mode_pend_r <= `MFC_MODE_UNIT;
               `MFC_STB_THIRD: mode_pend_r <= `MFC_MODE_SELFTEST;
               default: mode_pend_r <= mode_pend_r;
            endcase
         end
         if (!r_s_r[1] && scan_idx_r <= `MFC_STB_FOURTH) begin
            rsel_seen_r <= 1'b1;
            range_pend_r <= scan_idx_r[1:0];
         end
         ctl_acc_r[scan_idx_r] <= ~c_s_r[1];
         pt_acc_r[scan_idx_r] <= ~p_s_r[1];
         if (scan_idx_r == `MFC_STB_EIGHTH) begin
            // frame complete: commit all selections at once; the eighth
            // strobe's own pick has not reached the pending register yet
            if (!f_s_r[1]) o_mode <= `MFC_MODE_PERIOD;
            else if (fsel_seen_r) o_mode <= mode_pend_r;
            if (rsel_seen_r) o_range <= range_pend_r;
            fsel_seen_r <= 1'b0;
            rsel_seen_r <= 1'b0;
            o_sel_ext_osc <= ctl_acc_r[`MFC_STB_FIRST];
            o_sel_1mhz <= ctl_acc_r[`MFC_STB_SECOND];
            ext_pt_en_r <= ctl_acc_r[`MFC_STB_THIRD];
            o_display_test <= ~c_s_r[1];
            o_display_off <= ctl_acc_r[`MFC_STB_FOURTH] & h_s_r[1];
            ext_pt_r <= {~p_s_r[1], pt_acc_r[6:0]};
         end
      end else if (o_display_off && !h_s_r[1]) begin
         o_display_off <= 1'b0;
      end
   end

   // timebase to 100Hz tick
   assign tick = tb_fall &&
      (div_r == (o_sel_1mhz ? `MFC_DIV_1M : `MFC_DIV_10M));
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_r <= 17'h0;
      end else if (tb_fall) begin
         div_r <= tick ? 17'h0 : div_r + 17'h1;
      end
   end

   // routing per mode
   assign main_ev = (o_mode == `MFC_MODE_PERIOD ||
                     o_mode == `MFC_MODE_INTERVAL) ? tb_fall :
                    (o_mode == `MFC_MODE_SELFTEST) ? tb_fall :
                    a_fall;
   assign ref_ev = (o_mode == `MFC_MODE_PERIOD) ? a_fall :
                   (o_mode == `MFC_MODE_RATIO) ? b_fall :
                   (o_mode == `MFC_MODE_INTERVAL) ? b_fall :
                   tick;
   assign ref_inc_w = bcd_inc({16'h0, ref_r}, 4'h4);
   assign ref_inc = ref_inc_w[15:0];
   assign ref_end = ref_ev &&
      ((o_range == 2'h0 && ref_r == 16'h0000) ||
       (o_range == 2'h1 && ref_r == 16'h0009) ||
       (o_range == 2'h2 && ref_r == 16'h0099) ||
       (o_range == 2'h3 && ref_r == 16'h0999));
   assign main_inc = bcd_inc(main_r, 4'h8);

   // a mode change, or outside unit mode a range change or hold, throws away the window
   assign abort = (o_mode != mode_prev_r) ||
      (o_mode != `MFC_MODE_UNIT &&
       (o_range != range_prev_r || (h_s_r[1] && !hold_prev_r)));

   always @* begin
      main_nxt = main_r;
      ref_nxt = ref_r;
      if (ref_ev && gate_r) begin
         ref_nxt = ref_inc;
      end
      if (main_ev && gate_r) begin
         // interval counts only between an A fall and the next B fall
         if (o_mode != `MFC_MODE_INTERVAL || armed_r) begin
            main_nxt = main_inc;
         end
      end
   end

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         main_r <= 32'h0;
         ref_r <= 16'h0;
         gate_r <= 1'b0;
         armed_r <= 1'b0;
         load_r <= 1'b0;
         mode_prev_r <= `MFC_MODE_RST;
         range_prev_r <= `MFC_RANGE_RST;
         hold_prev_r <= 1'b0;
         o_meas_busy <= 1'b0;
         o_overflow <= 1'b0;
      end else begin
         mode_prev_r <= o_mode;
         range_prev_r <= o_range;
         hold_prev_r <= h_s_r[1];
         load_r <= 1'b0;
         if (o_mode == `MFC_MODE_UNIT) begin
            gate_r <= 1'b1;
            o_meas_busy <= 1'b1;
            if (a_fall) begin
               main_r <= main_inc;
               if (main_r == 32'h99999999) o_overflow <= 1'b1;
            end
            if (abort) begin
               main_r <= 32'h0;
               o_overflow <= 1'b0;
            end
            load_r <= !h_s_r[1];
         end else if (abort || h_s_r[1] || o_display_off) begin
            main_r <= 32'h0;
            ref_r <= 16'h0;
            gate_r <= 1'b0;
            armed_r <= 1'b0;
            o_meas_busy <= 1'b0;
         end else if (!gate_r) begin
            // window opens on the first reference event, or on the first A fall in interval mode
            if (o_mode == `MFC_MODE_INTERVAL ? a_fall : ref_ev) begin
               gate_r <= 1'b1;
               armed_r <= 1'b1;
               main_r <= 32'h0;
               ref_r <= 16'h0;
               o_overflow <= 1'b0;
               o_meas_busy <= 1'b1;
            end
         end else begin
            main_r <= main_nxt;
            ref_r <= ref_nxt;
            if (main_ev && main_r == 32'h99999999) o_overflow <= 1'b1;
            if (o_mode == `MFC_MODE_INTERVAL) begin
               if (a_fall) armed_r <= 1'b1;
               if (b_fall) armed_r <= 1'b0;
            end
            // single range: the next reference event after the start ends it
            if (o_mode == `MFC_MODE_INTERVAL ? (b_fall && armed_r &&
                  (o_range == 2'h0 || ref_end)) : ref_end) begin
               gate_r <= 1'b0;
               load_r <= 1'b1;
               o_meas_busy <= 1'b0;
            end
         end
      end
   end

   // decimal point per mode and range, kHz for frequency
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_point <= 8'h0;
      end else if (o_display_test) begin
         o_point <= 8'hff;
      end else if (ext_pt_en_r) begin
         o_point <= {o_overflow, ext_pt_r[6:0]};
      end else begin
         case (o_mode)
            `MFC_MODE_UNIT: o_point <= {o_overflow, 7'h01};
            `MFC_MODE_RATIO: o_point <= {o_overflow, 7'h01 << o_range};
            default: o_point <= {o_overflow, 7'h02 << o_range};
         endcase
      end
   end

   mfc_latch u_latch (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_load(load_r),
      .i_data(main_r),
      .o_data(o_display)
   );
endmodule
`default_nettype wire

// >>> dv/mfc_chk.sv
/*
 Checker for mfc_ctrl: scan, mode commit, hold and display rules.
 Assumes it is bound to every mfc_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mfc_chk #(
   parameter STROBE_CYC = 40
) (
   input wire i_clk,                  // system clock
   input wire i_reset_n,              // async reset, active low
   input wire i_hold,                 // hold level
   input wire [7:0] o_digit_strobe,   // digit scan
   input wire [2:0] o_mode,           // decoded mode
   input wire o_meas_busy,            // window open
   input wire [31:0] o_display        // latched count
);
   logic [31:0] cnt_r;
   function automatic bit bcd_ok(input logic [31:0] v);
      bcd_ok = 1'b1;
      for (int i = 0; i < 8; i++) if (v[4*i +: 4] > 4'h9) bcd_ok = 1'b0;
   endfunction
   // detection lags the change by one edge, hence the bound of STROBE_CYC
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) cnt_r <= 32'h0;
      else if ($changed(o_digit_strobe)) cnt_r <= 32'h0;
      else cnt_r <= cnt_r + 32'h1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   strobe_onehot_a:
   assert property ($onehot(o_digit_strobe)) else $error("strobe not one-hot");
   strobe_order_a:
   assert property ($changed(o_digit_strobe) |-> o_digit_strobe ==
      {$past(o_digit_strobe[6:0]), $past(o_digit_strobe[7])}) else $error("scan order");
   strobe_time_a:
   assert property (cnt_r <= STROBE_CYC) else $error("strobe held too long");
   mode_frame_a:
   assert property ($changed(o_mode) |-> o_digit_strobe[0] || o_digit_strobe[7])
      else $error("mode changed mid-frame");
   mode_legal_a:
   assert property (o_mode <= 3'h5) else $error("illegal mode");
   unit_busy_a:
   assert property ((o_mode == 3'h4)[*4] |-> o_meas_busy) else $error("unit not enabled");
   hold_frozen_a:
   assert property (i_hold[*8] |-> $stable(o_display)) else $error("display moved in hold");
   hold_idle_a:
   assert property ((i_hold && o_mode != 3'h4)[*8] |-> !o_meas_busy)
      else $error("busy during hold");
   display_bcd_a:
   assert property (bcd_ok(o_display)) else $error("display not bcd");
   cover property (o_mode == 3'h4 && o_meas_busy);
   cover property (i_hold[*8]);
   cover property ($fell(o_meas_busy));
endmodule
bind mfc_ctrl mfc_chk #(.STROBE_CYC(STROBE_CYC)) u_chk (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_hold(i_hold), .o_digit_strobe(o_digit_strobe),
   .o_mode(o_mode), .o_meas_busy(o_meas_busy), .o_display(o_display));
`default_nettype wire

// >>> dv/mfc_far_side.sv
/*
 Far side of mfc_ctrl: selection wiring to the strobes and signal sources.
 Assumes the bench clock; timebase runs free at an eighth of it.
*/
`timescale 1ns/1ps
`default_nettype none
module mfc_far_side (
   input wire logic i_clk,          // bench clock
   input wire logic [7:0] i_strobe, // digit scan from the block
   input wire logic [31:0] i_wire,  // masks: point, control, range, function
   input wire logic [7:0] i_a_half, // A half period, 0 parks A high
   input wire logic [7:0] i_b_half, // B half period, 0 parks B high
   input wire logic [5:0] i_b_lag,  // nonzero: B is A delayed
   output wire logic o_function_n,  // function line
   output wire logic o_range_n,     // range line
   output wire logic o_control_n,   // control line
   output wire logic o_point_n,     // external point line
   output var logic o_osc,          // timebase
   output var logic o_a,            // input A
   output wire logic o_b            // input B
);
   logic [7:0] ca, cb;
   logic [2:0] co;
   logic [63:0] hist;
   logic b_own;
   initial begin
      {ca, cb, co} = 19'h0;
      {hist, o_osc, o_a, b_own} = '1;
   end
   // lines follow the strobe at once, so they stand through its second half
   assign o_function_n = ~|(i_strobe & i_wire[7:0]);
   assign o_range_n = ~|(i_strobe & i_wire[15:8]);
   assign o_control_n = ~|(i_strobe & i_wire[23:16]);
   assign o_point_n = ~|(i_strobe & i_wire[31:24]);
   assign o_b = (i_b_lag != 6'h0) ? hist[i_b_lag] : b_own;
   always @(posedge i_clk) begin
      co <= co + 3'h1;
      if (co[1:0] == 2'h3) o_osc <= ~o_osc;
      hist <= {hist[62:0], o_a};
      ca <= (ca + 8'h1 >= i_a_half) ? 8'h0 : ca + 8'h1;
      cb <= (cb + 8'h1 >= i_b_half) ? 8'h0 : cb + 8'h1;
      if (i_a_half == 8'h0) o_a <= 1'b1;
      else if (ca + 8'h1 >= i_a_half) o_a <= ~o_a;
      if (i_b_half == 8'h0) b_own <= 1'b1;
      else if (cb + 8'h1 >= i_b_half) b_own <= ~b_own;
   end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/*
 Self-checking bench for mfc_ctrl with a short strobe period.
 Assumes mfc_far_side as wiring and sources, mfc_chk bound to the block.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int SC = 40;
   logic i_clk, i_reset_n, i_hold, a_q;
   logic [31:0] wires;
   logic [7:0] a_half, b_half;
   logic [5:0] b_lag;
   wire fn_n, rg_n, ct_n, pt_n, osc, in_a, in_b, doff, dtest, s1m, sext, busy, ovf;
   wire [7:0] stb, point;
   wire [2:0] mode;
   wire [1:0] range;
   wire [31:0] disp;
   int fails = 0, n_tests = 0, cycles = 0, a_falls = 0;
   mfc_ctrl #(.STROBE_CYC(SC)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_in_a(in_a), .i_in_b(in_b), .i_osc(osc), .i_ext_osc(osc), .i_hold(i_hold),
      .i_function_n(fn_n), .i_range_n(rg_n), .i_control_n(ct_n),
      .i_ext_point_select_line_n(pt_n), .o_digit_strobe(stb), .o_mode(mode),
      .o_range(range), .o_display_off(doff), .o_display_test(dtest), .o_sel_1mhz(s1m),
      .o_sel_ext_osc(sext), .o_point(point), .o_meas_busy(busy), .o_overflow(ovf),
      .o_display(disp));
   mfc_far_side far (.i_clk(i_clk), .i_strobe(stb), .i_wire(wires), .i_a_half(a_half),
      .i_b_half(b_half), .i_b_lag(b_lag), .o_function_n(fn_n), .o_range_n(rg_n),
      .o_control_n(ct_n), .o_point_n(pt_n), .o_osc(osc), .o_a(in_a), .o_b(in_b));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      a_q <= in_a;
      if (a_q && !in_a) a_falls <= a_falls + 1;
      if (cycles == 80000) begin
         fails = fails + 1;
         end_of_test;
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // selections commit once a frame; three frames cover sync and a late wire change
   task automatic sel(input logic [31:0] w);
      wires = w;
      cyc(24 * SC);
   endtask
   task automatic wt(input logic v);
      int k;
      k = 0;
      while (busy !== v && k < 5000) begin
         cyc(1);
         k++;
      end
      chk("busy", {31'h0, busy}, {31'h0, v});
   endtask
   function automatic int b2i(input logic [31:0] v);
      b2i = 0;
      for (int i = 7; i >= 0; i--) b2i = b2i * 10 + v[4*i +: 4];
   endfunction
   task automatic t_decode;
      logic [7:0] fm [6] = '{8'h01, 8'h80, 8'h02, 8'h10, 8'h08, 8'h04};
      for (int i = 0; i < 6; i++) begin
         sel({16'h0001, fm[i]} << 0 | {16'h0, 8'h01, 8'h0});
         chk("mode", {29'h0, mode}, i);
      end
      for (int i = 0; i < 4; i++) begin
         sel({16'h0, 8'h01 << i, 8'h01});
         chk("range", {30'h0, range}, i);
      end
      $display("test decode done");
   endtask
   task automatic t_control;
      sel(32'h04070101);
      chk("ext point", {31'h0, point[2]}, 1);
      chk("1mhz", {31'h0, s1m}, 1);
      chk("ext osc", {31'h0, sext}, 1);
      sel(32'h00800101);
      chk("disp test", {31'h0, dtest}, 1);
      i_hold = 1'b1;
      sel(32'h00080101);
      chk("disp off", {31'h0, doff}, 1);
      i_hold = 1'b0;
      sel(32'h00000101);
      chk("disp on", {31'h0, doff}, 0);
      $display("test control done");
   endtask
   task automatic t_meas(input string nm, input logic [31:0] w, input logic [7:0] ah,
         input logic [7:0] bh, input logic [5:0] lag, input int lo, input int hi);
      int v;
      a_half = ah;
      b_half = bh;
      b_lag = lag;
      sel(w);
      wt(1'b0);
      wt(1'b1);
      wt(1'b0);
      cyc(8);
      v = b2i(disp);
      chk(nm, {31'h0, v >= lo && v <= hi}, 1);
      chk("overflow", {31'h0, ovf}, 0);
      $display("test %s done, count %0d", nm, v);
   endtask
   task automatic t_hold;
      logic [31:0] d;
      i_hold = 1'b1;
      cyc(20);
      d = disp;
      cyc(600);
      chk("hold busy", {31'h0, busy}, 0);
      chk("hold display", disp, d);
      i_hold = 1'b0;
      wt(1'b1);
      $display("test hold done");
   endtask
   task automatic t_unit;
      int d0, n0;
      a_half = 8'h0;
      sel(32'h00000108);
      d0 = b2i(disp);
      n0 = a_falls;
      a_half = 8'd10;
      cyc(400);
      a_half = 8'h0;
      cyc(10);
      chk("unit count", b2i(disp) - d0, a_falls - n0);
      $display("test unit done");
   endtask
   initial begin
      {i_reset_n, i_hold, wires, a_half, b_half, b_lag} = 0;
      cyc(2);
      i_reset_n = 1'b1;
      chk("strobe", {24'h0, stb}, 32'h1);
      chk("mode", {29'h0, mode}, 32'h0);
      chk("range", {30'h0, range}, 32'h0);
      t_decode;
      t_control;
      t_meas("period", 32'h00000180, 8'd100, 8'd0, 6'd0, 24, 26);
      t_hold;
      t_meas("period x10", 32'h00000280, 8'd100, 8'd0, 6'd0, 245, 255);
      t_meas("ratio", 32'h00000102, 8'd10, 8'd100, 6'd0, 9, 11);
      t_meas("interval", 32'h00000110, 8'd100, 8'd0, 6'd40, 4, 6);
      t_meas("interval x10", 32'h00000210, 8'd100, 8'd0, 6'd40, 45, 55);
      t_unit;
      end_of_test;
   end
endmodule
`default_nettype wire
